// >>> hw/tone_osc_control.sv
// How it works
// - Status bit 7 shows oscillator output active
// - Oscillator one without reload stops after inactive timer expiry; oscillator two always restarts
// - With reload, restart and keep generating output
// - Zero-cross stop ends at next zero crossing
// - Zero-cross off ends signal at timer expiry
// - Oscillator two zero-cross stop works the same
// - Active timer enable bounds the on interval
// - Inactive timer enable bounds the off interval
// - Enable bit turns each oscillator on or off
// - Two-bit route: none, transmit, receive, both
// - Oscillator two has its own status bit
// - Timer expiry interrupts gated by enable bits
//
// Purpose: Control and status registers for two tone oscillators
// Assumes: Timer counts, zero crossings and interrupt enables come from
//   neighbouring logic; reg port is a byte-wide single-cycle port
// Notes: Timer step is 125 us, produced by a divider from the 100 MHz clock
`include "tone_osc_params.svh"

module tone_osc_control
  import tone_osc_pkg::*;
#(
  parameter logic [15:0] TICK_CYCLES = 16'(`TONE_TICK_CYCLES)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Interval lengths in timer steps
  input wire logic [15:0] tone_a_on_count,
  input wire logic [15:0] tone_a_off_count,
  input wire logic [15:0] tone_b_on_count,
  input wire logic [15:0] tone_b_off_count,
  // Zero crossing pulses from the waveform generators
  input wire logic tone_a_zero_cross,
  input wire logic tone_b_zero_cross,
  // Interrupt enables
  input wire logic tone_a_on_timer_irq_enable,
  input wire logic tone_a_off_timer_irq_enable,
  input wire logic tone_b_on_timer_irq_enable,
  input wire logic tone_b_off_timer_irq_enable,
  // Output routing
  output logic tone_a_tx_on,
  output logic tone_a_rx_on,
  output logic tone_b_tx_on,
  output logic tone_b_rx_on,
  // Status
  output logic tone_a_signal_active,
  output logic tone_b_signal_active,
  output logic tone_a_param_reload,
  // Interrupt event pulses
  output logic tone_a_on_timer_irq,
  output logic tone_a_off_timer_irq,
  output logic tone_b_on_timer_irq,
  output logic tone_b_off_timer_irq
);

  // ==========================================================
  // Declarations
  logic [7:0] ctrl_a_r, ctrl_a_nxt;
  logic [7:0] ctrl_b_r, ctrl_b_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [15:0] div_r, div_nxt;
  logic tick_r, tick_nxt;
  logic a_act, a_on_exp, a_off_exp;
  logic b_act, b_on_exp, b_off_exp;
  logic [10:0] out_r, out_nxt;
  logic sel_a, sel_b;

  assign sel_a = (reg_addr == `TONE_A_CTRL_ADDR);
  assign sel_b = (reg_addr == `TONE_B_CTRL_ADDR);

  // ==========================================================
  // Timer step divider
  always_comb begin
    tick_nxt = 1'b0;
    div_nxt = div_r + 16'h0001;
    if (div_r >= TICK_CYCLES - 16'h0001) begin
      div_nxt = 16'h0000;
      tick_nxt = 1'b1;
    end
  end

  // Divider registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ==========================================================
  // Control registers and read data
  always_comb begin
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    rdata_nxt = rdata_r;
    if (reg_write && sel_a) begin
      ctrl_a_nxt = reg_wdata & `TONE_A_WMASK; // Status bit not writable
    end
    if (reg_write && sel_b) begin
      ctrl_b_nxt = reg_wdata & `TONE_B_WMASK;
    end
    if (reg_read) begin
      if (sel_a) begin
        rdata_nxt = {a_act, ctrl_a_r[`CTRL_RELOAD_BIT:`CTRL_ROUTE_LO]};
      end else if (sel_b) begin
        rdata_nxt = {b_act, 1'b0, ctrl_b_r[`CTRL_ZC_BIT:`CTRL_ROUTE_LO]};
      end else begin
        rdata_nxt = `RDATA_RESET;
      end
    end
  end

  // Register bank
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_a_r <= `CTRL_RESET;
      ctrl_b_r <= `CTRL_RESET;
      rdata_r <= `RDATA_RESET;
    end else begin
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_r <= ctrl_b_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ==========================================================
  // Oscillator sequencers
  tone_sequencer #(
    .HAS_RELOAD(1'b1)
  ) u_seq_a (
    .clk(clk),
    .rst(rst),
    .tick(tick_r),
    .enable(ctrl_a_r[`CTRL_ENABLE_BIT]),
    .on_timer_enable(ctrl_a_r[`CTRL_ON_EN_BIT]),
    .off_timer_enable(ctrl_a_r[`CTRL_OFF_EN_BIT]),
    .zero_cross_stop(ctrl_a_r[`CTRL_ZC_BIT]),
    .auto_reload(ctrl_a_r[`CTRL_RELOAD_BIT]),
    .zero_cross(tone_a_zero_cross),
    .on_count(tone_a_on_count),
    .off_count(tone_a_off_count),
    .active(a_act),
    .on_expire(a_on_exp),
    .off_expire(a_off_exp)
  );

  tone_sequencer #(
    .HAS_RELOAD(1'b0)
  ) u_seq_b (
    .clk(clk),
    .rst(rst),
    .tick(tick_r),
    .enable(ctrl_b_r[`CTRL_ENABLE_BIT]),
    .on_timer_enable(ctrl_b_r[`CTRL_ON_EN_BIT]),
    .off_timer_enable(ctrl_b_r[`CTRL_OFF_EN_BIT]),
    .zero_cross_stop(ctrl_b_r[`CTRL_ZC_BIT]),
    .auto_reload(1'b0),
    .zero_cross(tone_b_zero_cross),
    .on_count(tone_b_on_count),
    .off_count(tone_b_off_count),
    .active(b_act),
    .on_expire(b_on_exp),
    .off_expire(b_off_exp)
  );

  // ==========================================================
  // Registered outputs: routing, status, reload and interrupts
  always_comb begin
    out_nxt[0] = a_act & ctrl_a_r[`ROUTE_TX_BIT];
    out_nxt[1] = a_act & ctrl_a_r[`ROUTE_RX_BIT];
    out_nxt[2] = b_act & ctrl_b_r[`ROUTE_TX_BIT];
    out_nxt[3] = b_act & ctrl_b_r[`ROUTE_RX_BIT];
    out_nxt[4] = a_act;
    out_nxt[5] = b_act;
    out_nxt[6] = a_off_exp & ctrl_a_r[`CTRL_RELOAD_BIT];
    out_nxt[7] = a_on_exp & tone_a_on_timer_irq_enable;
    out_nxt[8] = a_off_exp & tone_a_off_timer_irq_enable;
    out_nxt[9] = b_on_exp & tone_b_on_timer_irq_enable;
    out_nxt[10] = b_off_exp & tone_b_off_timer_irq_enable;
  end

  // Output flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_r <= 11'h000;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign tone_a_tx_on = out_r[0];
  assign tone_a_rx_on = out_r[1];
  assign tone_b_tx_on = out_r[2];
  assign tone_b_rx_on = out_r[3];
  assign tone_a_signal_active = out_r[4];
  assign tone_b_signal_active = out_r[5];
  assign tone_a_param_reload = out_r[6];
  assign tone_a_on_timer_irq = out_r[7];
  assign tone_a_off_timer_irq = out_r[8];
  assign tone_b_on_timer_irq = out_r[9];
  assign tone_b_off_timer_irq = out_r[10];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Expiry with zero-cross stop keeps signal until the crossing
  sequence s_a_drain_start;
    a_on_exp && ctrl_a_r[`CTRL_ZC_BIT] && ctrl_a_r[`CTRL_ENABLE_BIT];
  endsequence

  sequence s_a_drain_hold;
    a_act && !tone_a_zero_cross && ctrl_a_r[`CTRL_ENABLE_BIT];
  endsequence

  // Status bit read back matches the active state
  a_status_read_a: assert property (
    reg_read && sel_a |=> reg_rdata[`CTRL_STATUS_BIT] == $past(a_act)
      && tone_a_signal_active == $past(a_act))
    else $error("tone a status bit mismatch");

  a_status_read_b: assert property (
    reg_read && sel_b |=> reg_rdata[`CTRL_STATUS_BIT] == $past(b_act)
      && !reg_rdata[`CTRL_RELOAD_BIT])
    else $error("tone b status or bit 6 wrong");

  a_reload_stop_a: assert property (
    a_off_exp && !ctrl_a_r[`CTRL_RELOAD_BIT] && ctrl_a_r[`CTRL_ENABLE_BIT] |=> !a_act[*2])
    else $error("tone a did not stop without reload");

  a_reload_run_a: assert property (
    a_off_exp && ctrl_a_r[`CTRL_RELOAD_BIT] && ctrl_a_r[`CTRL_ENABLE_BIT]
    |=> a_act && tone_a_param_reload)
    else $error("tone a did not restart on reload");

  a_zero_cross_a: assert property (
    s_a_drain_start |=> a_act)
    else $error("tone a ended before zero crossing");

  // Without a crossing the tone keeps waiting
  a_drain_hold_a: assert property (
    s_a_drain_start ##1 s_a_drain_hold |=> a_act)
    else $error("tone a drain ended without a crossing");

  a_no_zc_stop_a: assert property (
    a_on_exp && !ctrl_a_r[`CTRL_ZC_BIT] |=> !a_act)
    else $error("tone a kept running after expiry");

  a_zero_cross_b: assert property (
    b_on_exp && ctrl_b_r[`CTRL_ZC_BIT] && ctrl_b_r[`CTRL_ENABLE_BIT] |=> b_act)
    else $error("tone b ended before zero crossing");

  a_timer_off_hold: assert property (
    a_act && !ctrl_a_r[`CTRL_ON_EN_BIT] && ctrl_a_r[`CTRL_ENABLE_BIT] && !tone_a_zero_cross
    |-> !a_on_exp ##1 a_act)
    else $error("tone a stopped with active timer off");

  a_off_timer_hold: assert property (
    !ctrl_b_r[`CTRL_OFF_EN_BIT] |-> !b_off_exp)
    else $error("tone b inactive timer ran while disabled");

  a_disable_stop: assert property (
    !ctrl_a_r[`CTRL_ENABLE_BIT] && !ctrl_b_r[`CTRL_ENABLE_BIT] |=> !a_act && !b_act)
    else $error("oscillator active while disabled");

  a_route_paths: assert property (
    ##1 tone_a_tx_on == $past(a_act && ctrl_a_r[`ROUTE_TX_BIT])
        && tone_b_rx_on == $past(b_act && ctrl_b_r[`ROUTE_RX_BIT]))
    else $error("output routing mismatch");

  a_route_more: assert property (
    ##1 tone_a_rx_on == $past(a_act && ctrl_a_r[`ROUTE_RX_BIT])
        && tone_b_tx_on == $past(b_act && ctrl_b_r[`ROUTE_TX_BIT]))
    else $error("output routing mismatch on the other paths");

  a_irq_gating: assert property (
    a_on_exp |=> tone_a_on_timer_irq == $past(tone_a_on_timer_irq_enable))
    else $error("interrupt not gated by its enable");

  a_irq_off_a: assert property (
    a_off_exp |=> tone_a_off_timer_irq == $past(tone_a_off_timer_irq_enable))
    else $error("tone a inactive interrupt not gated by its enable");

  a_irq_gating_b: assert property (
    b_on_exp || b_off_exp
    |=> tone_b_on_timer_irq == $past(b_on_exp && tone_b_on_timer_irq_enable)
        && tone_b_off_timer_irq == $past(b_off_exp && tone_b_off_timer_irq_enable))
    else $error("tone b interrupt not gated by its enable");

  a_bit6_zero_b: assert property (
    reg_write && sel_b |=> !ctrl_b_r[`CTRL_RELOAD_BIT])
    else $error("tone b bit 6 stored a write");

  a_alternate_b: assert property (
    b_off_exp && ctrl_b_r[`CTRL_ENABLE_BIT] |=> b_act ##1 tone_b_signal_active)
    else $error("tone b did not resume after off interval");

endmodule

// >>> hw/tone_osc_params.svh
// Purpose: Named constants for the dual tone oscillator control block
// Assumes: Included by the design modules
// Notes: Offsets are register numbers on the byte-wide register port
`ifndef TONE_OSC_PARAMS_SVH
`define TONE_OSC_PARAMS_SVH

// ==========================================================
// Register offsets
`define TONE_A_CTRL_ADDR 8'h20
`define TONE_B_CTRL_ADDR 8'h21

// ==========================================================
// Control register field positions
`define CTRL_STATUS_BIT 7
`define CTRL_RELOAD_BIT 6
`define CTRL_ZC_BIT 5
`define CTRL_ON_EN_BIT 4
`define CTRL_OFF_EN_BIT 3
`define CTRL_ENABLE_BIT 2
`define CTRL_ROUTE_HI 1
`define CTRL_ROUTE_LO 0
`define ROUTE_TX_BIT 0
`define ROUTE_RX_BIT 1

// ==========================================================
// Reset values and writable masks
`define CTRL_RESET 8'h00
`define TONE_A_WMASK 8'h7F
`define TONE_B_WMASK 8'h3F
`define RDATA_RESET 8'h00

// ==========================================================
// Timing: one timer step is 125 us, the clock period is 10 ns
`define TONE_TICK_NS 125000
`define TONE_CLK_NS 10
`define TONE_TICK_CYCLES (`TONE_TICK_NS / `TONE_CLK_NS)
`define CNT_WIDTH 16
`define CNT_ONE 16'h0001
`define CNT_ZERO 16'h0000

`endif

// >>> hw/tone_osc_pkg.sv
// Purpose: Shared types for the dual tone oscillator control block
// Assumes: Constants live in tone_osc_params.svh
// Notes: Sequencer state of one oscillator
package tone_osc_pkg;

  // ==========================================================
  // Oscillator sequence states
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_ON,
    SEQ_DRAIN,
    SEQ_OFF,
    SEQ_DONE
  } seq_state_e;

endpackage

// >>> hw/tone_sequencer.sv
// Purpose: On/off interval sequencer of one tone oscillator
// Assumes: tick is a one-cycle pulse every timer step
// Notes: HAS_RELOAD selects whether the off expiry restarts only on reload
`include "tone_osc_params.svh"

module tone_sequencer
  import tone_osc_pkg::*;
#(
  parameter bit HAS_RELOAD = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic tick,
  input wire logic enable,
  input wire logic on_timer_enable,
  input wire logic off_timer_enable,
  input wire logic zero_cross_stop,
  input wire logic auto_reload,
  input wire logic zero_cross,
  input wire logic [`CNT_WIDTH-1:0] on_count,
  input wire logic [`CNT_WIDTH-1:0] off_count,
  // Status
  output logic active,
  output logic on_expire,
  output logic off_expire
);

  seq_state_e state_r, state_nxt;
  logic [`CNT_WIDTH-1:0] cnt_r, cnt_nxt;
  logic restart;

  // Osc with no reload option always cycles when both timers run
  assign restart = HAS_RELOAD ? auto_reload : 1'b1;
  assign active = (state_r == SEQ_ON) || (state_r == SEQ_DRAIN);

  // ==========================================================
  // Next state and interval count
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    on_expire = 1'b0;
    off_expire = 1'b0;
    if (!enable) begin
      state_nxt = SEQ_IDLE;
    end else begin
      unique case (state_r)
        SEQ_IDLE: begin
          state_nxt = SEQ_ON;
          cnt_nxt = on_count;
        end
        SEQ_ON: begin
          if (on_timer_enable && tick) begin
            if (cnt_r <= `CNT_ONE) begin
              on_expire = 1'b1;
              if (zero_cross_stop) begin
                state_nxt = SEQ_DRAIN;
              end else if (off_timer_enable) begin
                state_nxt = SEQ_OFF;
                cnt_nxt = off_count;
              end else begin
                state_nxt = SEQ_DONE;
              end
            end else begin
              cnt_nxt = cnt_r - `CNT_ONE;
            end
          end
        end
        SEQ_DRAIN: begin
          if (zero_cross) begin
            state_nxt = off_timer_enable ? SEQ_OFF : SEQ_DONE;
            cnt_nxt = off_count;
          end
        end
        SEQ_OFF: begin
          if (off_timer_enable && tick) begin
            if (cnt_r <= `CNT_ONE) begin
              off_expire = 1'b1;
              if (restart) begin
                state_nxt = SEQ_ON;
                cnt_nxt = on_count;
              end else begin
                state_nxt = SEQ_DONE;
              end
            end else begin
              cnt_nxt = cnt_r - `CNT_ONE;
            end
          end
        end
        SEQ_DONE: begin
          state_nxt = SEQ_DONE;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= SEQ_IDLE;
      cnt_r <= `CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// >>> testbench/dual_tone_oscillator_control_tb.sv
// Purpose: Self-checking bench for the tone oscillator control registers
// Assumes: Byte register port, timer step shortened to 4 clock cycles
// Notes: Inputs change at the falling edge, outputs are sampled there too
module dual_tone_oscillator_control_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  localparam int LIMIT = 5000;
  logic clk, rst;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_write, reg_read;
  logic [15:0] a_on, a_off, b_on, b_off;
  logic zc_a, zc_b, ie_a_on, ie_a_off, ie_b_on, ie_b_off;
  logic a_tx, a_rx, b_tx, b_rx, a_act, b_act, a_rel;
  logic a_irq_on, a_irq_off, b_irq_on, b_irq_off;
  int fail_count, compares, cycles;
  int rises, falls, ion, ioff, tone_a_auto_reload, hi;

  // ==========================================================
  // Design under test
  tone_osc_control #(.TICK_CYCLES(16'h0004)) dut (
    .clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .tone_a_on_count(a_on), .tone_a_off_count(a_off),
    .tone_b_on_count(b_on), .tone_b_off_count(b_off),
    .tone_a_zero_cross(zc_a), .tone_b_zero_cross(zc_b),
    .tone_a_on_timer_irq_enable(ie_a_on), .tone_a_off_timer_irq_enable(ie_a_off),
    .tone_b_on_timer_irq_enable(ie_b_on), .tone_b_off_timer_irq_enable(ie_b_off),
    .tone_a_tx_on(a_tx), .tone_a_rx_on(a_rx), .tone_b_tx_on(b_tx), .tone_b_rx_on(b_rx),
    .tone_a_signal_active(a_act), .tone_b_signal_active(b_act),
    .tone_a_param_reload(a_rel),
    .tone_a_on_timer_irq(a_irq_on), .tone_a_off_timer_irq(a_irq_off),
    .tone_b_on_timer_irq(b_irq_on), .tone_b_off_timer_irq(b_irq_off)
  );

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hung run short
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      stop_test();
    end
  end

  // ==========================================================
  // Tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One write strobe held across one rising edge, then one idle edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
    @(negedge clk);
  endtask

  // Read strobe, data sampled once it has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask

  // Counts edges of the active flag and event pulses of one oscillator
  task automatic watch(input int osc, input int n);
    logic prev, act;
    rises = 0; falls = 0; ion = 0; ioff = 0; tone_a_auto_reload = 0; hi = 0;
    prev = osc ? b_act : a_act;
    repeat (n) begin
      @(negedge clk);
      act = osc ? b_act : a_act;
      rises += int'(act && !prev);
      falls += int'(!act && prev);
      hi += int'(act);
      ion += int'(osc ? b_irq_on : a_irq_on);
      ioff += int'(osc ? b_irq_off : a_irq_off);
      tone_a_auto_reload += int'(a_rel);
      prev = act;
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00; reg_write = 1'b0;
    reg_read = 1'b0; zc_a = 1'b0; zc_b = 1'b0;
    a_on = 16'h0003; a_off = 16'h0002; b_on = 16'h0002; b_off = 16'h0002;
    ie_a_on = 1'b1; ie_a_off = 1'b1; ie_b_on = 1'b1; ie_b_off = 1'b0;
    fail_count = 0; compares = 0; cycles = 0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    // Reset values, read-only and reserved bits, unmapped place
    rd(8'h20, d); check(d, 8'h00);
    rd(8'h21, d); check(d, 8'h00);
    wr(8'h21, 8'hFB); rd(8'h21, d); check(d, 8'h3B);
    wr(8'h20, 8'hFB); rd(8'h20, d); check(d, 8'h7B);
    rd(8'h22, d); check(d, 8'h00);
    wr(8'h20, 8'h00); wr(8'h21, 8'h00);
    // Every route code on both oscillators, timers off so the tone holds
    for (int o = 0; o < 2; o++) begin
      for (int r = 0; r < 4; r++) begin
        wr(8'(8'h20 + o), 8'(8'h04 + r));
        repeat (4) @(negedge clk);
        check(o ? {6'h0, b_rx, b_tx} : {6'h0, a_rx, a_tx}, 8'(r));
        rd(8'(8'h20 + o), d); check(d, 8'(8'h84 + r));
      end
      repeat (40) @(negedge clk);
      check({7'h0, o ? b_act : a_act}, 8'h01);
      wr(8'(8'h20 + o), 8'h00);
      repeat (4) @(negedge clk);
      check({7'h0, o ? b_act : a_act}, 8'h00);
      rd(8'(8'h20 + o), d); check(d, 8'h00);
    end
    // On timer alone, no zero-cross wait: one bounded burst then done
    wr(8'h20, 8'h15);
    watch(0, 60);
    check(8'(rises), 8'h01);
    check(8'(falls), 8'h01);
    check(8'(ion), 8'h01);
    check(8'((hi >= 8 && hi <= 16) ? 1 : 0), 8'h01);
    wr(8'h20, 8'h00);
    // Zero-cross stop holds the tone past expiry until the crossing
    a_on = 16'h0001;
    for (int o = 0; o < 2; o++) begin
      wr(8'(8'h20 + o), 8'h35);
      repeat (30) @(negedge clk);
      check({7'h0, o ? b_act : a_act}, 8'h01);
      if (o == 0) zc_a = 1'b1; else zc_b = 1'b1;
      @(negedge clk);
      zc_a = 1'b0; zc_b = 1'b0;
      repeat (4) @(negedge clk);
      check({7'h0, o ? b_act : a_act}, 8'h00);
      wr(8'(8'h20 + o), 8'h00);
    end
    // Both timers, no reload: one on and one off interval, then stop
    a_on = 16'h0003;
    wr(8'h20, 8'h1D);
    watch(0, 80);
    check(8'(rises), 8'h01);
    check(8'(falls), 8'h01);
    check(8'(ioff), 8'h01);
    wr(8'h20, 8'h00);
    // Reload set as for FSK: the tone keeps restarting
    wr(8'h20, 8'h5D);
    watch(0, 120);
    check(8'(rises >= 3 ? 1 : 0), 8'h01);
    check(8'(tone_a_auto_reload >= 2 ? 1 : 0), 8'h01);
    wr(8'h20, 8'h00);
    // Oscillator two alternates, off timer event masked
    wr(8'h21, 8'h1E);
    watch(1, 120);
    check(8'(rises >= 3 ? 1 : 0), 8'h01);
    check(8'(falls >= 3 ? 1 : 0), 8'h01);
    check(8'(ion >= 3 ? 1 : 0), 8'h01);
    check(8'(ioff), 8'h00);
    check({6'h0, b_rx, b_tx}, {6'h0, b_act, 1'b0});
    wr(8'h21, 8'h00);
    stop_test();
  end
endmodule
